// ### shared/irq_fifo_ctrl_defines.vh
// Constants for the interrupt identification and FIFO control block.
`ifndef IRQ_FIFO_CTRL_DEFINES_VH
`define IRQ_FIFO_CTRL_DEFINES_VH
`define ADDR_W              8
`define OFF_ID_CTRL         8'h08
`define OFF_IRQ_STATUS      8'h20
`define OFF_IRQ_MASK        8'h24
`define OFF_TX_LEVEL        8'h28
`define ID_CTRL_RESET       8'h01
`define BIT_TX_CLEAR        2
`define BIT_DMA_MODE        3
`define POS_THRESH          4
`define POS_RT              6
`define POS_FIFOE           0
`define POS_RFIFOR          1
`define CODE_NONE           4'h1
`define CODE_TX_EMPTY       4'h2
`define CODE_RX_DATA        4'h4
`define CODE_LINE           4'h6
`define CODE_BUSY           4'h7
`define CODE_TIMEOUT        4'hc
`define TX_DEPTH            5'h10
`define LVL_W               5
`define THRESH_EMPTY        2'h0
`define THRESH_TWO          2'h1
`define THRESH_QUARTER      2'h2
`define THRESH_HALF         2'h3
`define EV_W                3
`define EV_TX_EMPTY         0
`define EV_CLEAR            1
`define EV_DMA_TX           2
`endif

// ### src/irq_id_encode.v
// Priority encoder that turns pending interrupt sources into the four-bit code.
`timescale 1ns/1ps
`include "irq_fifo_ctrl_defines.vh"
module irq_id_encode (
	input  wire       line_status,
	input  wire       rx_data,
	input  wire       char_timeout,
	input  wire       tx_empty,
	input  wire       busy,
	output reg  [3:0] code
);
	// Only the single highest pending source is reported.
	always @* begin
		if (line_status) begin
			code = `CODE_LINE;
		end else if (rx_data) begin
			code = `CODE_RX_DATA;
		end else if (char_timeout) begin
			code = `CODE_TIMEOUT;
		end else if (tx_empty) begin
			code = `CODE_TX_EMPTY;
		end else if (busy) begin
			code = `CODE_BUSY;
		end else begin
			code = `CODE_NONE;
		end
	end
endmodule // irq_id_encode

// ### src/uart_irq_id_fifo_control.v
// Interrupt identification and FIFO control register with AXI4-Lite access.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "irq_fifo_ctrl_defines.vh"
module uart_irq_id_fifo_control (
	input  wire                core_clk,
	input  wire                reset_n,
	input  wire                clk_en,
	input  wire [`ADDR_W-1:0]  s_axi_awaddr,
	input  wire                s_axi_awvalid,
	output wire                s_axi_awready,
	input  wire [31:0]         s_axi_wdata,
	input  wire [3:0]          s_axi_wstrb,
	input  wire                s_axi_wvalid,
	output wire                s_axi_wready,
	output reg  [1:0]          s_axi_bresp,
	output reg                 s_axi_bvalid,
	input  wire                s_axi_bready,
	input  wire [`ADDR_W-1:0]  s_axi_araddr,
	input  wire                s_axi_arvalid,
	output wire                s_axi_arready,
	output reg  [31:0]         s_axi_rdata,
	output reg  [1:0]          s_axi_rresp,
	output reg                 s_axi_rvalid,
	input  wire                s_axi_rready,
	input  wire                prog_tx_empty_mode,
	input  wire                tx_empty_enable,
	input  wire                line_status_irq,
	input  wire                rx_data_irq,
	input  wire                char_timeout_irq,
	input  wire                busy_irq,
	input  wire                rx_req_level,
	input  wire [`LVL_W-1:0]   tx_level,
	input  wire                tx_done,
	output reg                 tx_queue_clear,
	output reg                 rx_queue_clear,
	output reg                 fifo_enable,
	output reg  [1:0]          rx_trigger,
	output wire                dma_tx_req_n,
	output wire                dma_rx_req_n,
	output reg  [1:0]          tx_empty_threshold,
	output reg                 transfer_request_signalling,
	output wire                irq
);
	reg                 aw_held_q;
	reg [`ADDR_W-1:0]   aw_addr_q;
	reg                 w_held_q;
	reg [31:0]          w_data_q;
	reg [3:0]           w_strb_q;
	reg [`EV_W-1:0]     status_q;
	reg [`EV_W-1:0]     mask_q;
	reg                 dma_tx_req_q;
	reg                 dma_rx_req_q;
	reg                 tx_empty_prev_q;
	reg                 dma_tx_prev_q;

	wire [3:0]          pending_interrupt_code;
	wire                tx_empty_irq;
	wire                at_threshold;
	wire                wr_fire;
	wire                rd_fire;
	wire                status_rd;
	wire [2:0]          wr_sel;
	wire [2:0]          rd_sel;
	wire [`EV_W-1:0]    events;
	genvar              g;

	// Register selectors shared by the write and read decoders.
	localparam [2:0] SEL_NONE   = 3'h0;
	localparam [2:0] SEL_CTRL   = 3'h1;
	localparam [2:0] SEL_STATUS = 3'h2;
	localparam [2:0] SEL_MASK   = 3'h3;
	localparam [2:0] SEL_LEVEL  = 3'h4;

	// Maps a byte address onto one of the mapped registers, or onto SEL_NONE when no register sits there.
	function [2:0] reg_sel;
		input [`ADDR_W-1:0] addr;
		begin
			case (addr)
				`OFF_ID_CTRL:    reg_sel = SEL_CTRL;
				`OFF_IRQ_STATUS: reg_sel = SEL_STATUS;
				`OFF_IRQ_MASK:   reg_sel = SEL_MASK;
				`OFF_TX_LEVEL:   reg_sel = SEL_LEVEL;
				default:         reg_sel = SEL_NONE;
			endcase
		end
	endfunction

	// Translates the two-bit threshold into a FIFO fill level.
	function [`LVL_W-1:0] thresh_level;
		input [1:0] sel;
		begin
			case (sel)
				`THRESH_EMPTY:   thresh_level = 5'h00;
				`THRESH_TWO:     thresh_level = 5'h02;
				`THRESH_QUARTER: thresh_level = `TX_DEPTH >> 2;
				`THRESH_HALF:    thresh_level = `TX_DEPTH >> 1;
				default:         thresh_level = 5'h00;
			endcase
		end
	endfunction

	// Level at or below the threshold; in plain mode only an empty queue counts.
	assign at_threshold = (tx_level <= thresh_level(tx_empty_threshold));
	assign tx_empty_irq = tx_empty_enable &
		(prog_tx_empty_mode ? at_threshold : (tx_level == 5'h00));

	irq_id_encode u_enc (
		.line_status  (line_status_irq),
		.rx_data      (rx_data_irq),
		.char_timeout (char_timeout_irq),
		.tx_empty     (tx_empty_irq),
		.busy         (busy_irq),
		.code         (pending_interrupt_code)
	);

	assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
	assign rd_fire = s_axi_arvalid & s_axi_arready;
	// The write side decodes the held address, the read side the live one.
	assign wr_sel = reg_sel(aw_addr_q);
	assign rd_sel = reg_sel(s_axi_araddr);
	// A taken read of the status register clears it; events still win that cycle.
	assign status_rd = rd_fire & (rd_sel == SEL_STATUS);

	// Write address capture; the data channel may arrive earlier or later.
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= {`ADDR_W{1'b0}};
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_q <= 1'b0;
			end
		end
	end

	// Write data capture; only the low byte lane matters for stored fields.
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			w_held_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (clk_en) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Write side fields live in their own flops, never in the code path.
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fifo_enable                 <= 1'b1;
			rx_trigger                  <= 2'h0;
			tx_empty_threshold          <= 2'h0;
			transfer_request_signalling <= 1'b0;
			tx_queue_clear              <= 1'b0;
			rx_queue_clear              <= 1'b0;
			mask_q                      <= {`EV_W{1'b0}};
			s_axi_bvalid                <= 1'b0;
			s_axi_bresp                 <= 2'h0;
		end else if (clk_en) begin
			tx_queue_clear <= 1'b0;
			rx_queue_clear <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				if (wr_sel == SEL_CTRL) begin
					if (w_strb_q[0]) begin
						tx_empty_threshold          <= w_data_q[`POS_THRESH+1:`POS_THRESH];
						rx_trigger                  <= w_data_q[`POS_RT+1:`POS_RT];
						transfer_request_signalling <= w_data_q[`BIT_DMA_MODE];
						tx_queue_clear              <= w_data_q[`BIT_TX_CLEAR];
						rx_queue_clear              <= w_data_q[`POS_RFIFOR];
						fifo_enable                 <= w_data_q[`POS_FIFOE];
						// Toggling the enable flushes both queues.
						if (w_data_q[`POS_FIFOE] != fifo_enable) begin
							tx_queue_clear <= 1'b1;
							rx_queue_clear <= 1'b1;
						end
					end
				end else if (wr_sel == SEL_MASK) begin
					if (w_strb_q[0]) begin
						mask_q <= w_data_q[`EV_W-1:0];
					end
				end else if (wr_sel == SEL_NONE) begin
					s_axi_bresp <= 2'h2;
				end
			end
		end
	end

	// Mode 0 follows the level; mode 1 holds the request until the burst is done.
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dma_tx_req_q <= 1'b0;
			dma_rx_req_q <= 1'b0;
		end else if (clk_en) begin
			if (!transfer_request_signalling) begin
				dma_tx_req_q <= (tx_level == 5'h00);
				dma_rx_req_q <= rx_req_level;
			end else begin
				// Releasing on a full queue too keeps a lost done pulse from pinning the request.
				if (at_threshold) begin
					dma_tx_req_q <= 1'b1;
				end else if (tx_done || tx_level == `TX_DEPTH) begin
					dma_tx_req_q <= 1'b0;
				end
				if (rx_req_level) begin
					dma_rx_req_q <= 1'b1;
				end else if (rx_data_irq == 1'b0) begin
					dma_rx_req_q <= 1'b0;
				end
			end
		end
	end
	assign dma_tx_req_n = ~dma_tx_req_q;
	assign dma_rx_req_n = ~dma_rx_req_q;

	// Edge detectors start low, so a level already high after reset counts once.
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_empty_prev_q <= 1'b0;
			dma_tx_prev_q   <= 1'b0;
		end else if (clk_en) begin
			tx_empty_prev_q <= tx_empty_irq;
			dma_tx_prev_q   <= dma_tx_req_q;
		end
	end
	assign events = {dma_tx_req_q & ~dma_tx_prev_q, tx_queue_clear,
		tx_empty_irq & ~tx_empty_prev_q};

	// One sticky flop per event; an event in the clearing read's cycle wins.
	generate
		for (g = 0; g < `EV_W; g = g + 1) begin : g_status
			always @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					status_q[g] <= 1'b0;
				end else if (clk_en) begin
					if (events[g]) begin
						status_q[g] <= 1'b1;
					end else if (status_rd) begin
						status_q[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Read data path; the answer stands until the master takes it.
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (clk_en) begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				s_axi_rdata  <= 32'h0000_0000;
				case (rd_sel)
					SEL_CTRL: begin
						// Upper code bits at 3:2, lower at 1:0; 7:6 show enable.
						s_axi_rdata[7:0] <= {{2{fifo_enable}}, 2'h0,
							pending_interrupt_code[3:2],
							pending_interrupt_code[1:0]};
					end
					SEL_STATUS: s_axi_rdata[`EV_W-1:0] <= status_q;
					SEL_MASK:   s_axi_rdata[`EV_W-1:0] <= mask_q;
					SEL_LEVEL:  s_axi_rdata[`LVL_W-1:0] <= tx_level;
					default:         s_axi_rresp <= 2'h2;
				endcase
			end
		end
	end

	assign irq = |(status_q & mask_q);
endmodule // uart_irq_id_fifo_control

// ### tb/id_ctrl_assertions.sv
// Checker for the interrupt id and FIFO control register.
`timescale 1ns/1ps
`include "irq_fifo_ctrl_defines.vh"
module id_ctrl_checker (
	input wire logic               core_clk,
	input wire logic               reset_n,
	input wire logic [`ADDR_W-1:0] s_axi_awaddr,
	input wire logic               s_axi_awvalid,
	input wire logic               s_axi_awready,
	input wire logic [31:0]        s_axi_wdata,
	input wire logic               s_axi_wvalid,
	input wire logic               s_axi_wready,
	input wire logic [1:0]         s_axi_bresp,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_bready,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire logic               tx_queue_clear,
	input wire logic [1:0]         tx_empty_threshold,
	input wire logic               transfer_request_signalling
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic [`ADDR_W-1:0] wa_q;
	logic [7:0]         wd_q;
	// The taken word is kept so the response edge can be judged against it.
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wa_q <= '0;
			wd_q <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
		end
	end
	sequence ctl_done;
		$rose(s_axi_bvalid) ##0 wa_q == `OFF_ID_CTRL;
	endsequence
	chk_fields_load: assert property (
		ctl_done |-> {tx_empty_threshold, transfer_request_signalling} == wd_q[5:3])
		else $error("fields not loaded");
	chk_clear_bit: assert property (ctl_done ##0 wd_q[2] |-> tx_queue_clear)
		else $error("no clear pulse");
	chk_clear_once: assert property (tx_queue_clear |=> !tx_queue_clear)
		else $error("clear not self clearing");
	chk_clear_cause: assert property (tx_queue_clear |-> $rose(s_axi_bvalid))
		else $error("clear without write");
	chk_bad_addr: assert property ($rose(s_axi_bvalid) && !(wa_q inside
		{8'h08, 8'h20, 8'h24, 8'h28}) |-> s_axi_bresp == 2'h2) else $error("no slave error");
	chk_one_write: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken");
	chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
	chk_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("response repeated");
endmodule // id_ctrl_checker
bind uart_irq_id_fifo_control id_ctrl_checker chk (.*);

// ### tb/dma_side_model.sv
// Behavioural DMA side: holds the transmit fill level and answers requests.
`timescale 1ns/1ps
`include "irq_fifo_ctrl_defines.vh"
module dma_side_model (
	input wire logic              core_clk,
	input wire logic              reset_n,
	input wire logic              dma_tx_req_n,
	input wire logic              serve,
	input wire logic [3:0]        lag,
	input wire logic              load,
	input wire logic [`LVL_W-1:0] load_level,
	output logic [`LVL_W-1:0]     tx_level,
	output logic                  tx_done
);
	logic [3:0] wait_q;
	logic       hit;
	assign hit = serve && !dma_tx_req_n && wait_q == lag;
	// Answering after lag cycles lets the bench choose a prompt or a slow burst.
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_level <= '0;
			tx_done <= '0;
			wait_q <= '0;
		end else begin
			tx_done <= hit;
			wait_q <= (serve && !dma_tx_req_n && !hit) ? wait_q + 4'h1 : 4'h0;
			if (load) tx_level <= load_level;
			else if (hit) tx_level <= `TX_DEPTH;
		end
	end
endmodule // dma_side_model

// ### tb/uart_irq_id_fifo_control_bench.sv
// Self-checking bench for the interrupt id and FIFO control register.
`timescale 1ns/1ps
`include "irq_fifo_ctrl_defines.vh"
module uart_irq_id_fifo_control_bench;
	logic core_clk = '0, reset_n = '0, clk_en = '1, prog_tx_empty_mode = '0;
	logic tx_empty_enable = '0;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
	logic s_axi_rready = '0, line_status_irq = '0, rx_data_irq = '0, char_timeout_irq = '0;
	logic busy_irq = '0, rx_req_level = '0, serve = '0, load = '0, tx_done;
	logic [`ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf, lag = '0, c;
	logic [`LVL_W-1:0] load_level = '0, tx_level;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic tx_queue_clear, rx_queue_clear, fifo_enable, dma_tx_req_n, dma_rx_req_n;
	logic transfer_request_signalling;
	logic [1:0] s_axi_bresp, s_axi_rresp, rx_trigger, tx_empty_threshold, bq[$];
	logic [65:0] rq[$], e;
	int miscompares = 0, checked = 0, clears = 0, rclears = 0, seed = 32'h1ba6baaf, n, i, s;
	uart_irq_id_fifo_control dut (.*);
	dma_side_model far (.*);
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	task cmp(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task hang;
		miscompares++;
		stop_test();
	endtask
	task axi(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [65:0] x);
		logic pa, pw, pb, ta, tw, tb;
		@(posedge core_clk);
		pa = 1'h1;
		pw = !rd;
		pb = 1'h1;
		if (rd) begin
			rq.push_back(x);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
		end else begin
			bq.push_back(x[65:64]);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
		end
		for (n = 0; pa || pw || pb; n++) begin
			if (n == 40) hang();
			@(negedge core_clk);
			ta = pa && (rd ? s_axi_arready : s_axi_awready);
			tw = pw && s_axi_wready;
			tb = pb && (rd ? s_axi_rvalid : s_axi_bvalid);
			@(posedge core_clk);
			if (ta && rd) s_axi_arvalid <= 1'h0;
			if (ta && !rd) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			if (tb && rd) s_axi_rready <= 1'h0;
			if (tb && !rd) s_axi_bready <= 1'h0;
			pa = pa && !ta;
			pw = pw && !tw;
			pb = pb && !tb;
		end
	endtask
	task lv(input logic [`LVL_W-1:0] l);
		@(posedge core_clk);
		load <= 1'h1;
		load_level <= l;
		@(posedge core_clk);
		load <= 1'h0;
	endtask
	task await(input logic v);
		for (n = 0; dma_tx_req_n !== v; n++) begin
			if (n == 60) hang();
			@(negedge core_clk);
		end
	endtask
	// Results are judged at the falling edge, where handshakes have settled.
	always @(negedge core_clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			e = rq.pop_front();
			cmp({s_axi_rresp, s_axi_rdata & e[63:32]}, {e[65:64], e[31:0]});
		end
		if (s_axi_bvalid && s_axi_bready) cmp(s_axi_bresp, bq.pop_front());
		if (tx_queue_clear) clears++;
		if (rx_queue_clear) rclears++;
	end
	initial begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'h1;
		axi(1, `OFF_ID_CTRL, 0, {34'hcf, 32'hc1});
		for (i = 0; i < 12; i++) begin
			s = $random(seed);
			{line_status_irq, rx_data_irq, char_timeout_irq, busy_irq} <= s[3:0];
			c = s[3] ? 4'h6 : s[2] ? 4'h4 : s[1] ? 4'hc : s[0] ? 4'h7 : 4'h1;
			axi(1, `OFF_ID_CTRL, 0, {34'hcf, 28'hc, c});
		end
		s = $random(seed);
		axi(0, `OFF_ID_CTRL, {24'h0, s[4:3], s[2:0], 3'h7}, 0);
		cmp({rx_trigger, tx_empty_threshold, transfer_request_signalling}, s[4:0]);
		cmp(clears, 1);
		cmp(rclears, 1);
		axi(1, `OFF_ID_CTRL, 0, {34'hcf, 28'hc, c});
		{line_status_irq, rx_data_irq, char_timeout_irq, busy_irq} <= 4'h0;
		prog_tx_empty_mode <= 1'h1;
		tx_empty_enable <= 1'h1;
		for (i = 0; i < 4; i++) begin
			axi(0, `OFF_ID_CTRL, {26'h0, i[1:0], 4'h1}, 0);
			rx_req_level <= i[0];
			lv(i == 0 ? 0 : 1 << i);
			axi(1, `OFF_ID_CTRL, 0, {34'hcf, 32'hc2});
			cmp({dma_tx_req_n, dma_rx_req_n}, {i != 0, !i[0]});
			lv(i == 0 ? 1 : (1 << i) + 1);
			axi(1, `OFF_ID_CTRL, 0, {34'hcf, 32'hc1});
		end
		axi(0, `OFF_IRQ_MASK, 32'h6, 0);
		axi(1, `OFF_IRQ_STATUS, 0, {34'h2, 32'h2});
		cmp(irq, 0);
		s = $random(seed);
		lag <= s[3:0];
		serve <= 1'h1;
		axi(0, `OFF_ID_CTRL, 32'h39, 0);
		lv(8);
		await(0);
		await(1);
		cmp({irq, tx_level}, {1'h1, `TX_DEPTH});
		axi(1, `OFF_IRQ_STATUS, 0, {34'h4, 32'h4});
		axi(0, 8'h40, 0, {2'h2, 64'h0});
		stop_test();
	end
endmodule // uart_irq_id_fifo_control_bench
